// File: core/twm_timer.sv
// Timer waveform mode decode, counter and compare output logic
//
// Operation
// - A nonzero output action field hands the channel pin to the compare output, except in mode 13 or where action 01 has no toggle.
// - In non-PWM modes action 00 disconnects, 01 toggles, 10 clears, 11 sets on match.
// - In fast PWM action 10 clears on match and sets at BOTTOM, 11 does the reverse.
// - In fast PWM action 01 toggles channel A only in modes 14 and 15, else disconnected.
// - In fast PWM a compare value equal to TOP ignores the match but keeps the BOTTOM action.
// - In dual-slope modes action 10 clears upcounting and sets downcounting, 11 reversed.
// - In dual-slope modes action 01 toggles channel A only in modes 9 and 11.
// - The mode is two low bits of control A joined with bits 4 and 3 of control B as its high bits.
// - Modes 1 to 3 are phase correct with TOP 0x00FF, 0x01FF, 0x03FF, reload at TOP.
// - Modes 5 to 7 are fast PWM with 8, 9, 10 bit TOP, reload at BOTTOM, flag at TOP.
// - Modes 0, 4 and 12 update compares at once and flag overflow at MAX.
// - Modes 8, 9 are frequency correct reloading at BOTTOM; 10, 11 phase correct at TOP.
// - Modes 14, 15 are fast PWM with TOP from capture or compare A; 13 is reserved.
// - Control A resets to zero and its two middle bits read as zero.
// - Dual-slope modes count up from zero to TOP and back down repeatedly.
//
// The Wishbone slave port was decided locally.
module twm_timer (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    output logic             compare_output_a_o,
    output logic             compare_output_a_en_o,
    output logic             compare_output_b_o,
    output logic             compare_output_b_en_o,
    output logic             irq_o
);
    ////////////////////////////////////////////////////////////////////////////
    // Registers and state
    logic [7:0]  ctrl_a, ctrl_b;
    logic [15:0] cmp_a_buf, cmp_b_buf;
    logic [15:0] compare_value_a, compare_value_b;
    logic [15:0] capture_value, counter_value;
    logic        count_down, out_a, out_b;
    logic [twm_pkg::IRQ_W-1:0] irq_stat, irq_en;
    logic        bus_req, bus_wr;
    logic [3:0]  waveform_mode_select;
    logic [1:0]  chan_a_output_action, chan_b_output_action;
    logic        running;
    twm_pkg::twm_kind_e  kind;
    twm_pkg::twm_point_e reload_at, ovf_at;
    logic [15:0] top, next_count;
    logic        at_top, at_bottom, at_max, wrap;
    logic        overflow_flag, match_a, match_b, reload;
    logic        next_down, next_out_a, next_out_b;
    logic [twm_pkg::IRQ_W-1:0] events, clr_bits;

    assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign bus_wr  = bus_req && wb_we_i && wb_sel_i[0];

    ////////////////////////////////////////////////////////////////////////////
    // Mode decode
    assign waveform_mode_select = {ctrl_b[twm_pkg::WHI_HI:twm_pkg::WHI_LO],
                                   ctrl_a[twm_pkg::WLO_HI:twm_pkg::WLO_LO]};
    assign chan_a_output_action = ctrl_a[twm_pkg::CHA_HI:twm_pkg::CHA_LO];
    assign chan_b_output_action = ctrl_a[twm_pkg::CHB_HI:twm_pkg::CHB_LO];
    assign running = ctrl_b[twm_pkg::CS_BIT];

    // Family, TOP source, reload and overflow points per mode
    always_comb begin
        kind      = twm_pkg::TWM_NONPWM;
        reload_at = twm_pkg::TWM_AT_NOW;
        ovf_at    = twm_pkg::TWM_AT_MAX;
        top       = twm_pkg::MAX;
        case (waveform_mode_select)
            twm_pkg::MODE_NORMAL:  top = twm_pkg::MAX;
            twm_pkg::MODE_CTC_A:   top = compare_value_a;
            twm_pkg::MODE_CTC_CAP: top = capture_value;
            twm_pkg::MODE_PC8, twm_pkg::MODE_PC9, twm_pkg::MODE_PC10: begin
                kind      = twm_pkg::TWM_DUAL;
                reload_at = twm_pkg::TWM_AT_TOP;
                ovf_at    = twm_pkg::TWM_AT_BOTTOM;
                top = (waveform_mode_select == twm_pkg::MODE_PC8) ? twm_pkg::TOP_8BIT :
                      (waveform_mode_select == twm_pkg::MODE_PC9) ? twm_pkg::TOP_9BIT :
                                                                   twm_pkg::TOP_10BIT;
            end
            twm_pkg::MODE_FP8, twm_pkg::MODE_FP9, twm_pkg::MODE_FP10: begin
                kind      = twm_pkg::TWM_FAST;
                reload_at = twm_pkg::TWM_AT_BOTTOM;
                ovf_at    = twm_pkg::TWM_AT_TOP;
                top = (waveform_mode_select == twm_pkg::MODE_FP8) ? twm_pkg::TOP_8BIT :
                      (waveform_mode_select == twm_pkg::MODE_FP9) ? twm_pkg::TOP_9BIT :
                                                                   twm_pkg::TOP_10BIT;
            end
            twm_pkg::MODE_PFC_CAP, twm_pkg::MODE_PFC_A: begin
                kind      = twm_pkg::TWM_DUAL;
                reload_at = twm_pkg::TWM_AT_BOTTOM;
                ovf_at    = twm_pkg::TWM_AT_BOTTOM;
                top = (waveform_mode_select == twm_pkg::MODE_PFC_A) ? compare_value_a
                                                                    : capture_value;
            end
            twm_pkg::MODE_PC_CAP, twm_pkg::MODE_PC_A: begin
                kind      = twm_pkg::TWM_DUAL;
                reload_at = twm_pkg::TWM_AT_TOP;
                ovf_at    = twm_pkg::TWM_AT_BOTTOM;
                top = (waveform_mode_select == twm_pkg::MODE_PC_A) ? compare_value_a
                                                                   : capture_value;
            end
            twm_pkg::MODE_FP_CAP, twm_pkg::MODE_FP_A: begin
                kind      = twm_pkg::TWM_FAST;
                reload_at = twm_pkg::TWM_AT_BOTTOM;
                ovf_at    = twm_pkg::TWM_AT_TOP;
                top = (waveform_mode_select == twm_pkg::MODE_FP_A) ? compare_value_a
                                                                   : capture_value;
            end
            twm_pkg::MODE_RSVD: kind = twm_pkg::TWM_RSVD;
            default:            kind = twm_pkg::TWM_RSVD;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // Counter sequence
    assign at_top    = (counter_value == top);
    assign at_bottom = (counter_value == twm_pkg::BOTTOM);
    assign at_max    = (counter_value == twm_pkg::MAX);
    assign wrap      = at_top || at_max;
    assign match_a   = running && (counter_value == compare_value_a);
    assign match_b   = running && (counter_value == compare_value_b);

    // Next count and direction
    always_comb begin
        next_count = counter_value;
        next_down  = count_down;
        if (running) begin
            case (kind)
                twm_pkg::TWM_DUAL: begin
                    if (at_top || counter_value > top) begin
                        next_down  = 1'b1;
                        next_count = counter_value - 16'h0001;
                    end else if (count_down && at_bottom) begin
                        next_down  = 1'b0;
                        next_count = counter_value + 16'h0001;
                    end else if (count_down) begin
                        next_count = counter_value - 16'h0001;
                    end else begin
                        next_count = counter_value + 16'h0001;
                    end
                end
                twm_pkg::TWM_RSVD: begin
                    next_count = twm_pkg::BOTTOM;
                    next_down  = 1'b0;
                end
                default: begin
                    next_down  = 1'b0;
                    next_count = wrap ? twm_pkg::BOTTOM : counter_value + 16'h0001;
                end
            endcase
        end
    end

    // Overflow event and compare reload point
    always_comb begin
        overflow_flag = 1'b0;
        reload        = 1'b0;
        if (running) begin
            case (ovf_at)
                twm_pkg::TWM_AT_MAX:    overflow_flag = at_max;
                twm_pkg::TWM_AT_TOP:    overflow_flag = at_top;
                twm_pkg::TWM_AT_BOTTOM: overflow_flag = at_bottom && count_down;
                default:                overflow_flag = 1'b0;
            endcase
            case (reload_at)
                twm_pkg::TWM_AT_TOP:    reload = at_top;
                twm_pkg::TWM_AT_BOTTOM: reload = (kind == twm_pkg::TWM_FAST) ? at_top
                                                 : (at_bottom && count_down);
                default:                reload = 1'b0;
            endcase
        end
    end

    // Counter and direction state
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            counter_value <= twm_pkg::WORD_RESET;
            count_down    <= 1'b0;
        end else begin
            counter_value <= next_count;
            count_down    <= next_down;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Compare output waveform
    always_comb begin
        next_out_a = out_a;
        next_out_b = out_b;
        case (kind)
            twm_pkg::TWM_NONPWM: begin
                if (match_a) begin
                    case (chan_a_output_action)
                        twm_pkg::ACT_TOGGLE: next_out_a = !out_a;
                        twm_pkg::ACT_CLEAR:  next_out_a = 1'b0;
                        twm_pkg::ACT_SET:    next_out_a = 1'b1;
                        default:             next_out_a = out_a;
                    endcase
                end
                if (match_b) begin
                    case (chan_b_output_action)
                        twm_pkg::ACT_TOGGLE: next_out_b = !out_b;
                        twm_pkg::ACT_CLEAR:  next_out_b = 1'b0;
                        twm_pkg::ACT_SET:    next_out_b = 1'b1;
                        default:             next_out_b = out_b;
                    endcase
                end
            end
            twm_pkg::TWM_FAST: begin
                // Match at TOP ignored; the BOTTOM action still follows
                if (chan_a_output_action[1] && running && at_top) begin
                    next_out_a = !chan_a_output_action[0];
                end else if (chan_a_output_action[1] && match_a) begin
                    next_out_a = chan_a_output_action[0];
                end else if (chan_a_output_action == twm_pkg::ACT_TOGGLE && match_a &&
                             waveform_mode_select[3:1] == twm_pkg::MODE_FP_CAP[3:1]) begin
                    next_out_a = !out_a;
                end
                if (chan_b_output_action[1] && running && at_top) begin
                    next_out_b = !chan_b_output_action[0];
                end else if (chan_b_output_action[1] && match_b) begin
                    next_out_b = chan_b_output_action[0];
                end
            end
            twm_pkg::TWM_DUAL: begin
                if (chan_a_output_action[1] && match_a) begin
                    next_out_a = chan_a_output_action[0] ^ count_down;
                end else if (chan_a_output_action == twm_pkg::ACT_TOGGLE && match_a &&
                             (waveform_mode_select == twm_pkg::MODE_PFC_A ||
                              waveform_mode_select == twm_pkg::MODE_PC_A)) begin
                    next_out_a = !out_a;
                end
                if (chan_b_output_action[1] && match_b) begin
                    next_out_b = chan_b_output_action[0] ^ count_down;
                end
            end
            default: begin
                next_out_a = 1'b0;
                next_out_b = 1'b0;
            end
        endcase
    end

    // Output latches, cleared to zero by reset
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            out_a <= 1'b0;
            out_b <= 1'b0;
        end else begin
            out_a <= next_out_a;
            out_b <= next_out_b;
        end
    end

    // Pin override; direction bit lives in the port logic
    always_comb begin
        compare_output_a_en_o = (chan_a_output_action != twm_pkg::ACT_OFF);
        compare_output_b_en_o = (chan_b_output_action != twm_pkg::ACT_OFF);
        if (chan_a_output_action == twm_pkg::ACT_TOGGLE) begin
            if (kind == twm_pkg::TWM_FAST) begin
                compare_output_a_en_o = waveform_mode_select[3:1] ==
                                        twm_pkg::MODE_FP_CAP[3:1];
            end else if (kind == twm_pkg::TWM_DUAL) begin
                compare_output_a_en_o = (waveform_mode_select == twm_pkg::MODE_PFC_A ||
                                         waveform_mode_select == twm_pkg::MODE_PC_A);
            end
        end
        if (chan_b_output_action == twm_pkg::ACT_TOGGLE && kind != twm_pkg::TWM_NONPWM) begin
            compare_output_b_en_o = 1'b0;
        end
        if (kind == twm_pkg::TWM_RSVD) begin
            compare_output_a_en_o = 1'b0;
            compare_output_b_en_o = 1'b0;
        end
    end
    assign compare_output_a_o = out_a;
    assign compare_output_b_o = out_b;

    ////////////////////////////////////////////////////////////////////////////
    // Software registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_a        <= twm_pkg::CTRL_RESET;
            ctrl_b        <= twm_pkg::CTRL_RESET;
            cmp_a_buf     <= twm_pkg::WORD_RESET;
            cmp_b_buf     <= twm_pkg::WORD_RESET;
            capture_value <= twm_pkg::WORD_RESET;
            irq_en        <= '0;
        end else if (bus_wr) begin
            case (wb_adr_i)
                twm_pkg::ADDR_CTRL_A:  ctrl_a <= wb_dat_i[7:0] & twm_pkg::CTRL_A_MASK;
                twm_pkg::ADDR_CTRL_B:  ctrl_b <= wb_dat_i[7:0] & twm_pkg::CTRL_B_MASK;
                twm_pkg::ADDR_CMP_A:   cmp_a_buf <= wb_dat_i[15:0];
                twm_pkg::ADDR_CMP_B:   cmp_b_buf <= wb_dat_i[15:0];
                twm_pkg::ADDR_CAPTURE: capture_value <= wb_dat_i[15:0];
                twm_pkg::ADDR_IRQ_EN:  irq_en <= wb_dat_i[twm_pkg::IRQ_W-1:0];
                default: ;
            endcase
        end
    end

    // Active compare values: immediate or buffered per mode
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            compare_value_a <= twm_pkg::WORD_RESET;
            compare_value_b <= twm_pkg::WORD_RESET;
        end else if (reload_at == twm_pkg::TWM_AT_NOW || reload) begin
            compare_value_a <= cmp_a_buf;
            compare_value_b <= cmp_b_buf;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Interrupt status; a new event wins over a clear
    assign events   = {match_b, match_a, overflow_flag};
    assign clr_bits = (bus_wr && wb_adr_i == twm_pkg::ADDR_IRQ_CLR) ?
                      wb_dat_i[twm_pkg::IRQ_W-1:0] : '0;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_stat <= '0;
        end else begin
            irq_stat <= (irq_stat & ~clr_bits) | events;
        end
    end
    assign irq_o = |(irq_stat & irq_en);

    ////////////////////////////////////////////////////////////////////////////
    // Bus answer, one cycle after the request
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= '0;
        end else begin
            wb_ack_o <= bus_req;
            wb_dat_o <= '0;
            if (bus_req && !wb_we_i) begin
                case (wb_adr_i)
                    twm_pkg::ADDR_CTRL_A:   wb_dat_o <= {24'h000000, ctrl_a};
                    twm_pkg::ADDR_CTRL_B:   wb_dat_o <= {24'h000000, ctrl_b};
                    twm_pkg::ADDR_CMP_A:    wb_dat_o <= {16'h0000, cmp_a_buf};
                    twm_pkg::ADDR_CMP_B:    wb_dat_o <= {16'h0000, cmp_b_buf};
                    twm_pkg::ADDR_CAPTURE:  wb_dat_o <= {16'h0000, capture_value};
                    twm_pkg::ADDR_COUNT:    wb_dat_o <= {16'h0000, counter_value};
                    twm_pkg::ADDR_IRQ_STAT: wb_dat_o <= {29'h0, irq_stat};
                    twm_pkg::ADDR_IRQ_EN:   wb_dat_o <= {29'h0, irq_en};
                    default:                wb_dat_o <= '0;
                endcase
            end
        end
    end
endmodule

// File: pkg/twm_pkg.sv
// Package for the timer waveform mode and compare output block
package twm_pkg;
    // Register byte offsets (word aligned on the bus)
    localparam logic [7:0] ADDR_CTRL_A   = 8'h80; // timer_output_and_wave_ctrl_a
    localparam logic [7:0] ADDR_CTRL_B   = 8'h84; // timer_ctrl_b (mode high bits)
    localparam logic [7:0] ADDR_CMP_A    = 8'h88; // compare_value_a
    localparam logic [7:0] ADDR_CMP_B    = 8'h8C; // compare_value_b
    localparam logic [7:0] ADDR_CAPTURE  = 8'h90; // capture_value
    localparam logic [7:0] ADDR_COUNT    = 8'h94; // counter_value (read only)
    localparam logic [7:0] ADDR_IRQ_STAT = 8'h98; // sticky status, read only
    localparam logic [7:0] ADDR_IRQ_EN   = 8'h9C; // interrupt enable
    localparam logic [7:0] ADDR_IRQ_CLR  = 8'hA0; // write one to clear
    // Control A field positions
    localparam int CHA_HI = 7;
    localparam int CHA_LO = 6;
    localparam int CHB_HI = 5;
    localparam int CHB_LO = 4;
    localparam int WLO_HI = 1;
    localparam int WLO_LO = 0;
    // Control B field positions
    localparam int WHI_HI = 4;
    localparam int WHI_LO = 3;
    localparam int CS_BIT = 0;
    // Writable masks and reset values
    localparam logic [7:0]  CTRL_A_MASK  = 8'hF3;
    localparam logic [7:0]  CTRL_B_MASK  = 8'h19;
    localparam logic [7:0]  CTRL_RESET   = 8'h00;
    localparam logic [15:0] WORD_RESET   = 16'h0000;
    // Count limits
    localparam logic [15:0] BOTTOM       = 16'h0000;
    localparam logic [15:0] MAX          = 16'hFFFF;
    localparam logic [15:0] TOP_8BIT     = 16'h00FF;
    localparam logic [15:0] TOP_9BIT     = 16'h01FF;
    localparam logic [15:0] TOP_10BIT    = 16'h03FF;
    // Output action encodings
    localparam logic [1:0] ACT_OFF    = 2'h0;
    localparam logic [1:0] ACT_TOGGLE = 2'h1;
    localparam logic [1:0] ACT_CLEAR  = 2'h2;
    localparam logic [1:0] ACT_SET    = 2'h3;
    // Interrupt status bits
    localparam int IRQ_OVF  = 0;
    localparam int IRQ_CMPA = 1;
    localparam int IRQ_CMPB = 2;
    localparam int IRQ_W    = 3;
    // Waveform mode numbers
    localparam logic [3:0] MODE_NORMAL  = 4'h0;
    localparam logic [3:0] MODE_PC8     = 4'h1;
    localparam logic [3:0] MODE_PC9     = 4'h2;
    localparam logic [3:0] MODE_PC10    = 4'h3;
    localparam logic [3:0] MODE_CTC_A   = 4'h4;
    localparam logic [3:0] MODE_FP8     = 4'h5;
    localparam logic [3:0] MODE_FP9     = 4'h6;
    localparam logic [3:0] MODE_FP10    = 4'h7;
    localparam logic [3:0] MODE_PFC_CAP = 4'h8;
    localparam logic [3:0] MODE_PFC_A   = 4'h9;
    localparam logic [3:0] MODE_PC_CAP  = 4'hA;
    localparam logic [3:0] MODE_PC_A    = 4'hB;
    localparam logic [3:0] MODE_CTC_CAP = 4'hC;
    localparam logic [3:0] MODE_RSVD    = 4'hD;
    localparam logic [3:0] MODE_FP_CAP  = 4'hE;
    localparam logic [3:0] MODE_FP_A    = 4'hF;
    // Waveform family
    typedef enum logic [1:0] {
        TWM_NONPWM = 2'b00,
        TWM_FAST   = 2'b01,
        TWM_DUAL   = 2'b11,
        TWM_RSVD   = 2'b10
    } twm_kind_e;
    // Reload and overflow points
    typedef enum logic [1:0] {
        TWM_AT_NOW    = 2'b00,
        TWM_AT_BOTTOM = 2'b01,
        TWM_AT_TOP    = 2'b11,
        TWM_AT_MAX    = 2'b10
    } twm_point_e;
endpackage

// File: verif/tb_twm_timer.sv
// Self-checking bench for the timer waveform mode block
module tb_twm_timer;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [7:0]  adr = 8'h00;
    logic [3:0]  sel = 4'h0;
    logic [31:0] dat = 32'h0, dat_o, rdat;
    logic        ack, oa, oae, ob, obe, irq;
    int          n_errors = 0, n_checks = 0, hi;
    // Rows: mode, action A, action B, expected enables A and B
    logic [9:0]  rows [12] = '{{4'h0, 2'h2, 2'h1, 2'h3}, {4'h4, 2'h3, 2'h3, 2'h3},
        {4'hC, 2'h3, 2'h0, 2'h2}, {4'h5, 2'h1, 2'h1, 2'h0}, {4'hE, 2'h1, 2'h1, 2'h2},
        {4'hF, 2'h1, 2'h2, 2'h3}, {4'h9, 2'h1, 2'h1, 2'h2}, {4'hB, 2'h1, 2'h3, 2'h3},
        {4'h1, 2'h1, 2'h1, 2'h0}, {4'hD, 2'h2, 2'h2, 2'h0}, {4'h8, 2'h0, 2'h2, 2'h1},
        {4'h7, 2'h2, 2'h1, 2'h2}};
    // Waveform rows: mode, action A, compare A, period, high cycles, tolerance
    int          pm [12][6] = '{'{1, 2, 64, 510, 128, 4}, '{1, 3, 64, 510, 382, 4},
        '{2, 2, 64, 1022, 128, 4}, '{5, 2, 64, 256, 65, 2}, '{5, 3, 64, 256, 191, 2},
        '{5, 2, 255, 256, 256, 0}, '{7, 2, 64, 1024, 65, 2}, '{14, 2, 32, 128, 33, 2},
        '{4, 1, 63, 128, 64, 2}, '{6, 2, 64, 512, 65, 2}, '{10, 2, 32, 254, 64, 4},
        '{3, 3, 64, 2046, 1918, 4}};
    always #5 clk_i = ~clk_i;
    twm_timer dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dat_o),
        .wb_ack_o(ack), .compare_output_a_o(oa), .compare_output_a_en_o(oae),
        .compare_output_b_o(ob), .compare_output_b_en_o(obe), .irq_o(irq));
    ////////////////////////////////////////////////////////////////////////////////
    // Report and end the run
    task automatic test_done();
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // Classic single bus cycle, entered just after a clock edge
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                       input logic [3:0] s);
        int n;
        n = 0;
        {cyc, stb, we, adr, sel, dat} <= {2'b11, w, a, s, d};
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 50);
        if (n >= 50) n_errors++;
        rdat = dat_o;
        {cyc, stb} <= 2'b00;
        @(posedge clk_i);
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %0t got %0h exp %0h", $time, got, exp);
        end
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        foreach (rows[i]) begin
            bus(1'b1, twm_pkg::ADDR_CTRL_B, {27'h0, rows[i][9:8], 3'h1}, 4'h1);
            bus(1'b1, twm_pkg::ADDR_CTRL_A, {24'h0, rows[i][5:2], 2'h3, rows[i][7:6]}, 4'hF);
            bus(1'b0, twm_pkg::ADDR_CTRL_A, 32'h0, 4'hF);
            chk(rdat, {24'h0, rows[i][5:2], 2'h0, rows[i][7:6]});
            chk({30'h0, oae, obe}, {30'h0, rows[i][1:0]});
        end
        foreach (pm[i]) begin
            rst_i <= 1'b1;
            repeat (2) @(posedge clk_i);
            rst_i <= 1'b0;
            @(posedge clk_i);
            bus(1'b1, twm_pkg::ADDR_CMP_A, 32'(pm[i][2]), 4'hF);
            bus(1'b1, twm_pkg::ADDR_CAPTURE, 32'h7F, 4'hF);
            bus(1'b1, twm_pkg::ADDR_CTRL_A, 32'(pm[i][1] * 64 + pm[i][0] % 4), 4'hF);
            bus(1'b1, twm_pkg::ADDR_CTRL_B, 32'(pm[i][0] / 4 * 8 + 1), 4'hF);
            repeat (3 * pm[i][3]) @(posedge clk_i);
            hi = 0;
            repeat (pm[i][3]) begin
                @(posedge clk_i);
                hi += (oa === 1'b1) ? 1 : 0;
            end
            n_checks++;
            if (hi < pm[i][4] - pm[i][5] || hi > pm[i][4] + pm[i][5]) begin
                n_errors++;
                $display("[ERR] %0t got %0h exp %0h", $time, hi, pm[i][4]);
            end
        end
        // Overflow and match flags raise, mask and clear the interrupt
        bus(1'b1, twm_pkg::ADDR_IRQ_EN, 32'h7, 4'hF);
        chk({31'h0, irq}, 32'h1);
        bus(1'b1, twm_pkg::ADDR_IRQ_EN, 32'h0, 4'hF);
        chk({31'h0, irq}, 32'h0);
        bus(1'b1, twm_pkg::ADDR_CTRL_B, 32'h0, 4'hF);
        bus(1'b1, twm_pkg::ADDR_IRQ_CLR, 32'h7, 4'hF);
        bus(1'b0, twm_pkg::ADDR_IRQ_STAT, 32'h0, 4'hF);
        chk(rdat, 32'h0);
        // Reset, lane-gated write and unmapped read
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        chk({30'h0, oae, obe}, 32'h0);
        bus(1'b1, twm_pkg::ADDR_CTRL_A, 32'hF3, 4'hE);
        bus(1'b0, 8'hFC, 32'h0, 4'hF);
        chk(rdat, 32'h0);
        bus(1'b0, twm_pkg::ADDR_CTRL_A, 32'h0, 4'hF);
        chk(rdat, 32'h0);
        test_done();
    end
    // Watchdog against a hung handshake
    initial begin
        #400000;
        n_errors++;
        test_done();
    end
endmodule

bind twm_timer twm_timer_properties chk_u (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .compare_output_a_o(compare_output_a_o), .compare_output_a_en_o(compare_output_a_en_o),
    .compare_output_b_o(compare_output_b_o), .compare_output_b_en_o(compare_output_b_en_o));

// File: verif/twm_timer_properties.sv
// Checker for bus handshake, pin hand-over and compare output levels
module twm_timer_properties (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    input  wire logic [31:0] wb_dat_o,
    input  wire logic        wb_ack_o,
    input  wire logic        compare_output_a_o,
    input  wire logic        compare_output_a_en_o,
    input  wire logic        compare_output_b_o,
    input  wire logic        compare_output_b_en_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic [7:0] sha, shb;
    logic [3:0] md;
    logic       take, pwm, ena, enb;
    ////////////////////////////////////////////////////////////////////////////////
    // Shadow of both control registers, updated on the taking edge
    assign take = wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i && wb_sel_i[0];
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sha <= 8'h00;
            shb <= 8'h00;
        end else if (take && wb_adr_i == twm_pkg::ADDR_CTRL_A) begin
            sha <= wb_dat_i[7:0] & twm_pkg::CTRL_A_MASK;
        end else if (take && wb_adr_i == twm_pkg::ADDR_CTRL_B) begin
            shb <= wb_dat_i[7:0] & twm_pkg::CTRL_B_MASK;
        end
    end
    // Expected pin hand-over from mode and action fields
    assign md  = {shb[4:3], sha[1:0]};
    assign pwm = !(md inside {4'h0, 4'h4, 4'hC, 4'hD});
    assign ena = sha[7:6] != 2'h0 && md != 4'hD
                 && !(sha[7:6] == 2'h1 && pwm && !(md inside {4'h9, 4'hB, 4'hE, 4'hF}));
    assign enb = sha[5:4] != 2'h0 && md != 4'hD && !(sha[5:4] == 2'h1 && pwm);
    ////////////////////////////////////////////////////////////////////////////////
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) // Bus pulse
        else $error("ack held too long");
    ack_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) // Bus reply
        else $error("request not acknowledged");
    dat_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0) // Bus idle data
        else $error("read data outside ack");
    ctrl_read_a: assert property (
        wb_ack_o && !wb_we_i && wb_adr_i == twm_pkg::ADDR_CTRL_A |-> wb_dat_o == {24'h0, sha})
        else $error("control A readback wrong");
    en_a_map_a: assert property (compare_output_a_en_o == ena)
        else $error("channel A hand-over wrong");
    en_b_map_a: assert property (compare_output_b_en_o == enb)
        else $error("channel B hand-over wrong");
    rsvd_low_a: assert property (
        (md == 4'hD) [*2] |-> !compare_output_a_o && !compare_output_b_o)
        else $error("output active in reserved mode");
    clr_hold_a: assert property (
        md == 4'h0 && sha[7:6] == 2'h2 && $stable(sha) && $stable(md)
        |-> !$rose(compare_output_a_o)) else $error("clear action raised output");
    set_hold_a: assert property (
        md == 4'h4 && sha[7:6] == 2'h3 && $stable(sha) && $stable(md)
        |-> !$fell(compare_output_a_o)) else $error("set action lowered output");
endmodule
